/* verilog/floppy_support_pkg.sv */
package floppy_support_pkg;

  // host port addresses (10-bit i/o space)
  localparam logic [9:0] PORT_OUTPUT_CTRL = 10'h3F2;
  localparam logic [9:0] PORT_INPUT_RATE  = 10'h3F7;
  localparam logic [9:0] PORT_CTRL_STATUS = 10'h3F4;
  localparam logic [9:0] PORT_CTRL_DATA   = 10'h3F5;

  // drive_output_control field positions
  localparam int OUT_MOTOR_B_BIT = 5;
  localparam int OUT_MOTOR_A_BIT = 4;
  localparam int OUT_GATE_BIT    = 3;
  localparam int OUT_RESET_BIT   = 2;
  localparam int OUT_SEL_HI_BIT  = 1;
  localparam int OUT_SEL_LO_BIT  = 0;

  // drive_input_status field positions
  localparam int IN_CHANGED_BIT = 7;
  localparam int IN_EXT_B_BIT   = 6;
  localparam int IN_EXT_A_BIT   = 5;
  localparam int IN_ANY_SEL_BIT = 4;

  // reset values
  localparam logic [5:0] OUTPUT_CTRL_RESET = 6'h00;
  localparam logic [1:0] RATE_RESET        = 2'h0;
  localparam logic [7:0] READ_DATA_RESET   = 8'h00;

  // transfer rate codes
  typedef enum logic [1:0] {
    RATE_500K = 2'h0,
    RATE_300K = 2'h1,
    RATE_250K = 2'h2,
    RATE_NONE = 2'h3
  } rate_code_t;

  // host i/o access
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       rd_n;
    logic       wr_n;
  } host_io_t;

  // drive-facing controls
  typedef struct packed {
    logic sel_a_n;
    logic sel_b_n;
    logic motor_a_n;
    logic motor_b_n;
  } drive_ctrl_t;

endpackage

/* verilog/drive_select_decode.sv */
`timescale 1ns/1ps
module drive_select_decode
  import floppy_support_pkg::*;
(
  // register fields
  input  wire logic              sel_hi,
  input  wire logic              sel_lo,
  input  wire logic              motor_a,
  input  wire logic              motor_b,
  // decoded drive lines
  output drive_ctrl_t            drive,
  output logic                   any_sel
);
  // 1x selects nothing; only 00 and 01 map to a drive
  always_comb begin
    drive.sel_a_n   = ~(~sel_hi & ~sel_lo);
    drive.sel_b_n   = ~(~sel_hi & sel_lo);
    drive.motor_a_n = ~motor_a;
    drive.motor_b_n = ~motor_b;
    any_sel         = (~sel_hi & ~sel_lo) | (~sel_hi & sel_lo);
  end
endmodule

/* verilog/floppy_drive_support_regs.sv */
`timescale 1ns/1ps
// Behaviour
// - reads of 3F7H return input status; writes there load rate register
// - bit 7 reports disk possibly changed since last use
// - changed flag reads 0 whenever external drive is in use
// - bit 6 is 1 when switch puts external drive as drive B
// - bit 5 is 1 when switch puts external drive as drive A
// - bit 4 is OR of drive A and drive B selects
// - drive-active OR also driven out to memory controller array
// - 3F2H write loads motors, gate, controller reset, drive select
// - rate register write-only, rate in low two bits
// - rate codes 00 500k, 01 300k, 10 250k, 11 unused
// - controller chip select for ports 3F4H and 3F5H, A9..A1
// - terminal count and dma ack gated by output bit 3
// - controller reset output driven from output bit 2
module floppy_drive_support_regs
  import floppy_support_pkg::*;
(
  // system
  input  wire logic                          clk,
  input  wire logic                          rst,
  // host i/o
  input  floppy_support_pkg::host_io_t       host,
  input  wire logic                          floppy_port_sel_n,
  output logic [7:0]                         rdata,
  output logic                               rdata_oe,
  // floppy controller chip
  output logic                               controller_chip_sel_n,
  output logic                               controller_reset_out,
  input  wire logic                          terminal_count_in,
  input  wire logic                          dma_ack_n_in,
  output logic                               gated_terminal_count,
  output logic                               gated_dma_ack_n,
  output logic                               irq_dma_gate,
  // drives and switch
  input  wire logic                          media_changed_in,
  input  wire logic                          ext_switch_active,
  input  wire logic                          ext_first_drive_n,
  output floppy_support_pkg::drive_ctrl_t    drive,
  output logic                               ext_in_use,
  output floppy_support_pkg::rate_code_t     rate_code,
  // memory controller array
  output logic                               any_drive_selected
);
  import floppy_support_pkg::*;

  // registered state
  logic [5:0]  out_ctrl_r;
  logic [5:0]  out_ctrl_nxt;
  logic [1:0]  rate_r;
  logic [1:0]  rate_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  // bus decode
  logic        port_hit;
  logic        addr_out_ctrl;
  logic        addr_input_rate;
  logic        wr_active;
  logic        rd_active;
  logic        wr_out;
  logic        wr_rate;
  logic        rd_in;

  // status path
  logic        any_sel;
  logic        ext_b;
  logic        ext_a;
  logic [7:0]  status;

  // the port-select arrives already qualified by the memory controller
  // array, which also keeps dma cycles out, so only the full address
  // is compared here; a host cycle outside 3F0H..3F7H never gets
  // past the port-select
  always_comb begin
    port_hit        = ~floppy_port_sel_n;
    addr_out_ctrl   = (host.addr == PORT_OUTPUT_CTRL);
    addr_input_rate = (host.addr == PORT_INPUT_RATE);
    wr_active       = port_hit & ~host.wr_n;
    rd_active       = port_hit & ~host.rd_n;
  end

  // register strobes; the read and the write of 3F7H reach different
  // registers, so direction must be part of every strobe.  a strobe
  // lasts as long as the host holds its command level
  always_comb begin
    wr_out  = wr_active & addr_out_ctrl;
    wr_rate = wr_active & addr_input_rate;
    rd_in   = rd_active & addr_input_rate;
  end

  // next value of the output control register; bits 7:6 carry nothing
  // and are dropped, and writes to other ports leave it alone
  always_comb begin
    out_ctrl_nxt = out_ctrl_r;
    if (rst) begin
      out_ctrl_nxt = OUTPUT_CTRL_RESET;
    end else if (wr_out) begin
      out_ctrl_nxt = host.wdata[5:0];
    end
  end

  // the cleared value holds the controller chip in reset with both
  // motors off until software has written the register
  always_ff @(posedge clk) begin
    out_ctrl_r <= out_ctrl_nxt;
  end

  // next value of the rate register; only the code bits are kept, and
  // the unused code 11 is stored as written, so software must avoid it
  always_comb begin
    rate_nxt = rate_r;
    if (rst) begin
      rate_nxt = RATE_RESET;
    end else if (wr_rate) begin
      rate_nxt = host.wdata[1:0];  // upper bits dropped
    end
  end

  // write-only: nothing reads this register back, the port returns the
  // input status instead
  always_ff @(posedge clk) begin
    rate_r <= rate_nxt;
  end

  // drive select and motor decode; code 1x selects no drive, so software
  // can park both select lines without touching the motor bits.  the
  // motor lines come straight from register bits, while each select line is decoded from both select bits
  drive_select_decode i_drive_select_decode (
    .sel_hi  (out_ctrl_r[OUT_SEL_HI_BIT]),
    .sel_lo  (out_ctrl_r[OUT_SEL_LO_BIT]),
    .motor_a (out_ctrl_r[OUT_MOTOR_A_BIT]),
    .motor_b (out_ctrl_r[OUT_MOTOR_B_BIT]),
    .drive   (drive),
    .any_sel (any_sel)
  );

  // switch decode: off is 0/1, drive B is 1/1, drive A is 1/0; the
  // fourth pattern 0/0 is not a switch position and reports neither
  always_comb begin
    ext_b      = ext_switch_active & ext_first_drive_n;
    ext_a      = ext_switch_active & ~ext_first_drive_n;
    ext_in_use = ext_switch_active;
  end

  // status image; the change line is only trusted for the internal
  // drive, so an active switch masks it.  bits 3:0 are unused and
  // read 0
  always_comb begin
    status                 = 8'h00;
    status[IN_CHANGED_BIT] = media_changed_in
                             & ~ext_switch_active;
    status[IN_EXT_B_BIT]   = ext_b;
    status[IN_EXT_A_BIT]   = ext_a;
    status[IN_ANY_SEL_BIT] = any_sel;
  end

  // read data is captured on the read edge, so the host sees a value
  // that does not follow the switch or the change line mid-cycle; the
  // cost is one cycle of latency after the read edge
  always_comb begin
    rdata_nxt = rdata_r;
    if (rst) begin
      rdata_nxt = READ_DATA_RESET;
    end else if (rd_in) begin
      rdata_nxt = status;
    end
  end

  // the captured byte stands until the next read of the status port
  always_ff @(posedge clk) begin
    rdata_r <= rdata_nxt;
  end

  // host read bus; the enable follows the strobe so the data bus is
  // released in the same cycle in which the read ends
  always_comb begin
    rdata    = rdata_r;
    rdata_oe = rd_in;
  end

  // interrupt and dma gating: with the gate bit low the controller
  // chip sees neither a terminal count nor an acknowledge, and the
  // request lines are held off through irq_dma_gate
  always_comb begin
    irq_dma_gate         = out_ctrl_r[OUT_GATE_BIT];
    gated_terminal_count = terminal_count_in
                           & out_ctrl_r[OUT_GATE_BIT];
    gated_dma_ack_n      = dma_ack_n_in
                           | ~out_ctrl_r[OUT_GATE_BIT];
  end

  // controller reset is the inverse of bit 2, so the cleared register
  // after system reset holds the chip in reset
  always_comb begin
    controller_reset_out = ~out_ctrl_r[OUT_RESET_BIT];
  end

  // chip select for the data and main status registers; A0 picks the
  // register inside the controller chip and is left out of the compare.
  // it decodes the address alone, without the port-select
  always_comb begin
    controller_chip_sel_n = ~(host.addr[9:1]
                              == PORT_CTRL_STATUS[9:1]);
  end

  // drive activity goes out to the memory controller array as well,
  // which uses it to tell whether the floppy subsystem is busy; it is
  // the same term that status bit 4 reports
  always_comb begin
    any_drive_selected = any_sel;
  end

  // rate code output; code 11 passes through unchanged and has no
  // defined rate
  always_comb begin
    rate_code = rate_code_t'(rate_r);
  end

endmodule

/* bench/port_sel_model.sv */
`timescale 1ns/1ps
module port_sel_model (
  // host address in, port select out
  input  wire logic [9:0] addr,
  output logic            floppy_port_sel_n
);
  // dma qualifier left out: the bench never runs dma cycles
  assign floppy_port_sel_n = (addr[9:3] != 7'h7E);
endmodule

/* bench/floppy_regs_checker_sva.sv */
`timescale 1ns/1ps
module floppy_regs_checker
  import floppy_support_pkg::*;
(
  // watched ports
  input  wire logic       clk,
  input  wire logic       rst,
  input  host_io_t        host,
  input  wire logic       floppy_port_sel_n,
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_oe,
  input  wire logic       controller_chip_sel_n,
  input  wire logic       controller_reset_out,
  input  wire logic       terminal_count_in,
  input  wire logic       gated_terminal_count,
  input  wire logic       irq_dma_gate,
  input  wire logic       media_changed_in,
  input  wire logic       ext_switch_active,
  input  wire logic       ext_first_drive_n,
  input  drive_ctrl_t     drive,
  input  rate_code_t      rate_code,
  input  wire logic       any_drive_selected
);
  // qualified strobes and the status byte a read should capture
  wire hit = !floppy_port_sel_n;
  wire rd_st = hit && !host.rd_n && host.addr == PORT_INPUT_RATE;
  wire wr_ok = hit && !host.wr_n;
  wire [7:0] st = {media_changed_in & !ext_switch_active,
    ext_switch_active & ext_first_drive_n,
    ext_switch_active & !ext_first_drive_n, any_drive_selected, 4'h0};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_oe; rdata_oe == rd_st; endproperty
  a_oe: assert property (p_oe) else $error("bad oe");
  property p_st; rd_st |=> rdata == $past(st); endproperty
  a_st: assert property (p_st) else $error("bad st");
  property p_any;
    any_drive_selected == !(drive.sel_a_n && drive.sel_b_n);
  endproperty
  a_any: assert property (p_any) else $error("bad any");
  property p_ctl; wr_ok && host.addr == PORT_OUTPUT_CTRL |=>
    controller_reset_out == !$past(host.wdata[2]) &&
    irq_dma_gate == $past(host.wdata[3]); endproperty
  a_ctl: assert property (p_ctl) else $error("bad ctl");
  property p_rate; wr_ok && host.addr == PORT_INPUT_RATE |=>
    rate_code == $past(host.wdata[1:0]); endproperty
  a_rate: assert property (p_rate) else $error("bad rate");
  property p_cs; controller_chip_sel_n == (host.addr[9:1] != 9'h1FA);
  endproperty
  a_cs: assert property (p_cs) else $error("bad cs");
  property p_tc;
    gated_terminal_count == (terminal_count_in && irq_dma_gate);
  endproperty
  a_tc: assert property (p_tc) else $error("bad tc");
  property p_rst; $past(rst) |-> rate_code == RATE_500K &&
    controller_reset_out && !irq_dma_gate; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
endmodule
bind floppy_drive_support_regs floppy_regs_checker i_floppy_regs_checker (
  .clk, .rst, .host, .floppy_port_sel_n, .rdata, .rdata_oe,
  .controller_chip_sel_n, .controller_reset_out, .terminal_count_in,
  .gated_terminal_count, .irq_dma_gate, .media_changed_in,
  .ext_switch_active, .ext_first_drive_n, .drive, .rate_code,
  .any_drive_selected
);

/* bench/floppy_drive_support_regs_tb.sv */
`timescale 1ns/1ps
module floppy_drive_support_regs_tb;
  import floppy_support_pkg::*;
  logic clk = 1'h0, rst = 1'h1;
  logic terminal_count_in = 1'h1, dma_ack_n_in = 1'h0; // show the gate
  logic media_changed_in = 1'h0, ext_switch_active = 1'h0;
  logic ext_first_drive_n = 1'h1;
  host_io_t host = '{10'h000, 8'h00, 1'h1, 1'h1};
  logic floppy_port_sel_n, rdata_oe, controller_chip_sel_n;
  logic controller_reset_out, gated_terminal_count, gated_dma_ack_n;
  logic irq_dma_gate, ext_in_use, any_drive_selected;
  logic [7:0] rdata, e;
  drive_ctrl_t drive;
  rate_code_t rate_code;
  int failures = 0, checked = 0;
  port_sel_model i_port_sel_model (.addr(host.addr), .floppy_port_sel_n);
  floppy_drive_support_regs i_floppy_drive_support_regs (
    .clk, .rst, .host, .floppy_port_sel_n, .rdata, .rdata_oe,
    .controller_chip_sel_n, .controller_reset_out, .terminal_count_in,
    .dma_ack_n_in, .gated_terminal_count, .gated_dma_ack_n, .irq_dma_gate,
    .media_changed_in, .ext_switch_active, .ext_first_drive_n, .drive,
    .ext_in_use, .rate_code, .any_drive_selected);
  initial forever #2.5 clk = ~clk;
  task automatic summarize();
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle access, released on the next falling edge
  task automatic acc(input logic [9:0] a, input logic [7:0] d, input w);
    @(negedge clk);
    host = '{a, d, w, !w};
    @(negedge clk);
    host = '{a, d, 1'h1, 1'h1};
  endtask
  task automatic t_ctrl();
    logic [7:0] d [4] = '{8'h1C, 8'hE9, 8'h33, 8'h02};
    foreach (d[i]) begin
      acc(PORT_OUTPUT_CTRL, d[i], 1'h1);
      acc(10'h3F6, ~d[i], 1'h1); // unmapped, must change nothing
      e = {!d[i][2], d[i][3], !d[i][3], d[i][1:0] != 2'h0,
        d[i][1:0] != 2'h1, !d[i][4], !d[i][5], !d[i][1]};
      chk({controller_reset_out, gated_terminal_count, gated_dma_ack_n,
        drive, any_drive_selected}, e);
    end
  endtask
  task automatic t_rate();
    for (int c = 0; c < 4; c++) begin
      acc(PORT_INPUT_RATE, {6'h2A, c[1:0]}, 1'h1);
      acc(PORT_INPUT_RATE, 8'h00, 1'h0); // a read leaves the rate alone
      chk({6'h00, rate_code}, {6'h00, c[1:0]});
    end
  endtask
  task automatic t_status();
    acc(PORT_OUTPUT_CTRL, 8'h14, 1'h1);
    for (int i = 0; i < 6; i++) begin
      {ext_switch_active, ext_first_drive_n} = i < 2 ? 2'h1 : 2'h3 - i[2];
      media_changed_in = i[0];
      acc(PORT_INPUT_RATE, 8'h00, 1'h0);
      e = {i < 2 && i[0], i / 2 == 1, i / 2 == 2, 1'h1, 4'h0};
      chk(rdata, e);
      chk({7'h00, ext_in_use}, {7'h00, i >= 2});
    end
  endtask
  task automatic t_decode();
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      host.addr = i < 8 ? 10'h3F0 + i[9:0] : 10'h1F4;
      #1;
      chk({7'h00, controller_chip_sel_n}, {7'h00, i != 4 && i != 5});
    end
  endtask
  initial begin
    #20000;
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    chk({controller_reset_out, irq_dma_gate, drive, rate_code}, 8'h9C);
    t_ctrl();
    t_rate();
    t_status();
    t_decode();
    summarize();
  end
endmodule
